// ===== src/pll_ctrl_pkg.sv
/*
 * Shared constants for the synthesizer control and status register bank:
 * addresses, field positions, reset words, writable masks and codes.
 * Assumes both link ends and the bench import it.
 */
package pll_ctrl_pkg;

    localparam int WORD_W = 32;
    localparam int ADDR_W = 3;
    localparam int RD_BIT = 31;

    // address codes in bits 2:0 of every word
    localparam logic [ADDR_W-1:0] ADDR_REG0 = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DIV = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h6;

    localparam logic [WORD_W-1:0] MODE_RESET = 32'h00000043;
    localparam logic [WORD_W-1:0] DIV_RESET = 32'h00000004;
    // bits that are stored; everything else except the read bit and address reads as zero
    localparam logic [WORD_W-1:0] MODE_USED_MASK = 32'h0003fff8;
    localparam logic [WORD_W-1:0] DIV_USED_MASK = 32'h003ffff8;
    localparam logic [WORD_W-1:0] ADDR_MASK = 32'h00000007;

    // mode and test configuration fields
    localparam int ZERO_FRAC_SEL_BIT = 17;
    localparam int PUMP_TEST_HI = 16;
    localparam int PUMP_TEST_LO = 15;
    localparam int REINIT_POLICY_BIT = 14;
    localparam int OUTPUT_CLAMP_BIT = 13;
    localparam int LINEARITY_HI = 12;
    localparam int LINEARITY_LO = 11;
    localparam int INTEGER_MODE_BIT = 10;
    localparam int LD_ALGO_BIT = 9;
    localparam int LD_SPEED_BIT = 8;
    localparam int LD_WINDOW_BIT = 7;
    localparam int POLARITY_BIT = 6;
    localparam int POWER_DOWN_BIT = 5;
    localparam int PUMP_HIZ_BIT = 4;
    localparam int COUNTER_HOLD_BIT = 3;

    // divider and conversion control fields
    localparam int REF_OFF_BIT = 21;
    localparam int DIV_FN_HI = 20;
    localparam int DIV_FN_LO = 19;
    localparam int DIV_VAL_HI = 18;
    localparam int DIV_VAL_LO = 7;
    localparam int CONV_SRC_HI = 6;
    localparam int CONV_SRC_LO = 4;
    localparam int CONV_START_BIT = 3;
    localparam int DIV_VAL_W = DIV_VAL_HI - DIV_VAL_LO + 1;

    // readback status fields
    localparam int POR_FLAG_BIT = 11;
    localparam int CONV_VALID_BIT = 10;
    localparam int RESULT_HI = 9;
    localparam int RESULT_LO = 3;
    localparam int RESULT_W = RESULT_HI - RESULT_LO + 1;

    localparam logic [1:0] PUMP_TEST_NORMAL = 2'h0;
    localparam logic [1:0] PUMP_TEST_SOURCE = 2'h2;
    localparam logic [1:0] PUMP_TEST_SINK = 2'h3;
    localparam logic [1:0] LINEARITY_OFF = 2'h0;
    localparam logic [1:0] DIV_FN_OFF = 2'h0;
    localparam logic [1:0] DIV_FN_FAST_LOCK = 2'h1;
    localparam logic [1:0] DIV_FN_PHASE_ADJ = 2'h2;
    localparam logic [1:0] DIV_FN_CONV_CLK = 2'h3;
    localparam logic [2:0] CONV_SRC_OFF = 3'h0;
    localparam logic [2:0] CONV_SRC_TEMP = 3'h1;

    // lock-detect speed threshold on the comparison frequency
    localparam int LD_SPEED_LIMIT_MHZ = 32;
    localparam logic [17:0] LD_SPEED_LIMIT_KHZ = 18'(LD_SPEED_LIMIT_MHZ * 1000);

endpackage

// ===== src/pll_ctrl_link_if.sv
/*
 * Word link between the host controller and the register bank.
 * Assumes both ends run on the same ref_clk, supplied outside.
 */
`timescale 1ns/1ns
`default_nettype none
interface pll_ctrl_link_if;
    import pll_ctrl_pkg::*;

    logic word_valid;
    logic [WORD_W-1:0] word;
    logic rdata_valid;
    logic [WORD_W-1:0] rdata;

    modport device (
        input word_valid,
        input word,
        output rdata_valid,
        output rdata
    );

    modport host (
        output word_valid,
        output word,
        input rdata_valid,
        input rdata
    );
endinterface
`default_nettype wire

// ===== src/pll_ctrl_host.sv
/*
 * Host end: turns user commands into register words, waits for readback.
 * Assumes the device end answers a read within a few cycles on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pll_ctrl_host (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // link to the register bank
    pll_ctrl_link_if.host link,
    // user commands
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [pll_ctrl_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [pll_ctrl_pkg::WORD_W-1:0] cmd_data,
    input wire logic [17:0] comparator_freq_khz,
    // user answers
    output logic rsp_valid,
    output logic [pll_ctrl_pkg::WORD_W-1:0] rsp_data,
    output logic cmd_refused
);
    import pll_ctrl_pkg::*;

    typedef enum logic {IDLE, WAIT_RSP} host_state_type;

    host_state_type state, next_state;
    logic word_valid, next_word_valid;
    logic [WORD_W-1:0] word, next_word;
    logic rsp_valid_q, next_rsp_valid;
    logic [WORD_W-1:0] rsp_q, next_rsp;
    logic refused, next_refused;
    logic [WORD_W-1:0] body;

    assign cmd_ready = (state == IDLE);
    assign link.word_valid = word_valid;
    assign link.word = word;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_q;
    assign cmd_refused = refused;

    always_comb begin
        body = '0;
        next_state = state;
        next_word_valid = 1'b0;
        next_word = word;
        next_rsp_valid = 1'b0;
        next_rsp = rsp_q;
        next_refused = 1'b0;
        case (state)
            IDLE: begin
                if (cmd_valid) begin
                    if (cmd_read) begin
                        next_word = {1'b1, {(WORD_W-1-ADDR_W){1'b0}}, cmd_addr};
                        next_word_valid = 1'b1;
                        next_state = WAIT_RSP;
                    end else if (cmd_addr == ADDR_DIV
                            && cmd_data[DIV_VAL_HI:DIV_VAL_LO] == '0) begin
                        next_refused = 1'b1;
                    end else begin
                        body = cmd_data;
                        if (cmd_addr == ADDR_MODE) begin
                            body = cmd_data & MODE_USED_MASK;
                            body[LD_SPEED_BIT] = (comparator_freq_khz > LD_SPEED_LIMIT_KHZ);
                        end else if (cmd_addr == ADDR_DIV) begin
                            body = cmd_data & DIV_USED_MASK;
                        end
                        body[RD_BIT] = 1'b0;
                        next_word = (body & ~ADDR_MASK) | {{(WORD_W-ADDR_W){1'b0}}, cmd_addr};
                        next_word_valid = 1'b1;
                    end
                end
            end
            WAIT_RSP: begin
                if (link.rdata_valid) begin
                    next_rsp = link.rdata;
                    next_rsp_valid = 1'b1;
                    next_state = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= IDLE;
            word_valid <= 1'b0;
            word <= '0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            refused <= 1'b0;
        end else begin
            state <= next_state;
            word_valid <= next_word_valid;
            word <= next_word;
            rsp_valid_q <= next_rsp_valid;
            rsp_q <= next_rsp;
            refused <= next_refused;
        end
    end
endmodule
`default_nettype wire

// ===== src/pll_ctrl_device.sv
/*
 * Device end: mode, divider and status registers of the synthesizer,
 * with decoded control outputs to the analog and counter logic.
 * Assumes the host follows the word format and that the converter,
 * fraction-zero and register 0..2 logic live on ref_clk beside it.
 */
`timescale 1ns/1ns
`default_nettype none
module pll_ctrl_device #(
    parameter int RES_W = 7
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // link from the host
    pll_ctrl_link_if.device link,
    // synthesizer state inputs
    input wire logic fraction_zero,
    input wire logic conversion_done,
    input wire logic [RES_W-1:0] conversion_result,
    // loop and lock-detect controls
    output logic integer_mode,
    output logic pump_force_source,
    output logic pump_force_sink,
    output logic pump_linearity_mode,
    output logic pump_output_clamp,
    output logic pump_hiz,
    output logic phase_polarity_positive,
    output logic lock_detect_algorithm,
    output logic lock_detect_speed,
    output logic lock_detect_window,
    output logic software_power_down,
    output logic counters_hold,
    output logic modulator_reinit,
    // reference, divider and converter controls
    output logic reference_stage_off,
    output logic [1:0] divider_function_select,
    output logic [pll_ctrl_pkg::DIV_VAL_W-1:0] divider_value,
    output logic [2:0] converter_source_select,
    output logic conversion_start,
    // words for registers kept outside this bank
    output logic ext_write_valid,
    output logic [pll_ctrl_pkg::WORD_W-1:0] ext_write_word
);
    import pll_ctrl_pkg::*;

    // refused at elaboration: the status word has room for exactly this width
    if (RES_W != RESULT_W) begin : g_res_w_check
        $error("result width must match the status field");
    end

    logic [WORD_W-1:0] mode_reg, next_mode_reg;
    logic [WORD_W-1:0] div_reg, next_div_reg;
    logic por_pending, next_por_pending;
    logic conv_valid, next_conv_valid;
    logic [RES_W-1:0] conv_result, next_conv_result;
    logic rdata_valid, next_rdata_valid;
    logic [WORD_W-1:0] rdata, next_rdata;
    logic reinit_pulse, next_reinit_pulse;
    logic start_pulse, next_start_pulse;
    logic ext_valid, next_ext_valid;
    logic [WORD_W-1:0] ext_word, next_ext_word;

    logic is_read, is_write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] status_word;
    logic [WORD_W-1:0] div_candidate;

    // readback carries the read bit and the register's own address
    function automatic logic [WORD_W-1:0] tag_word(input logic [WORD_W-1:0] body,
                                                   input logic [ADDR_W-1:0] a);
        logic [WORD_W-1:0] w;
        w = body & ~ADDR_MASK;
        w[RD_BIT] = 1'b1;
        w = w | {{(WORD_W-ADDR_W){1'b0}}, a};
        return w;
    endfunction

    assign is_read = link.word_valid & link.word[RD_BIT];
    assign is_write = link.word_valid & ~link.word[RD_BIT];
    assign addr = link.word[ADDR_W-1:0];

    always_comb begin
        status_word = '0;
        status_word[POR_FLAG_BIT] = por_pending;
        status_word[CONV_VALID_BIT] = conv_valid;
        status_word[RESULT_HI:RESULT_LO] = conv_result;
    end

    always_comb begin
        div_candidate = link.word & DIV_USED_MASK;
        // a zero divider is never stored; the old value is kept
        if (div_candidate[DIV_VAL_HI:DIV_VAL_LO] == '0) begin
            div_candidate[DIV_VAL_HI:DIV_VAL_LO] = div_reg[DIV_VAL_HI:DIV_VAL_LO];
        end
    end

    always_comb begin
        next_mode_reg = mode_reg;
        next_div_reg = div_reg;
        next_por_pending = por_pending;
        next_conv_valid = conv_valid;
        next_conv_result = conv_result;
        next_rdata_valid = 1'b0;
        next_rdata = rdata;
        next_reinit_pulse = 1'b0;
        next_start_pulse = 1'b0;
        next_ext_valid = 1'b0;
        next_ext_word = ext_word;
        if (is_write) begin
            case (addr)
                ADDR_MODE: begin
                    next_mode_reg = link.word & MODE_USED_MASK;
                end
                ADDR_DIV: begin
                    next_div_reg = div_candidate;
                    // start only counts with the temperature sensor routed
                    if (link.word[CONV_START_BIT]
                            && link.word[CONV_SRC_HI:CONV_SRC_LO] == CONV_SRC_TEMP) begin
                        next_start_pulse = 1'b1;
                        next_conv_valid = 1'b0;
                    end
                end
                default: begin
                    next_ext_valid = 1'b1;
                    next_ext_word = link.word;
                    if (addr == ADDR_REG0 && !mode_reg[REINIT_POLICY_BIT]) begin
                        next_reinit_pulse = 1'b1;
                    end
                end
            endcase
        end
        if (is_read) begin
            next_rdata_valid = 1'b1;
            case (addr)
                ADDR_MODE: next_rdata = tag_word(mode_reg, addr);
                ADDR_DIV: next_rdata = tag_word(div_reg, addr);
                ADDR_STATUS: begin
                    next_rdata = tag_word(status_word, addr);
                    next_por_pending = 1'b0;
                end
                default: next_rdata = tag_word('0, addr);
            endcase
        end
        // a result arriving with a new start still lands
        if (conversion_done) begin
            next_conv_valid = 1'b1;
            next_conv_result = conversion_result;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mode_reg <= MODE_RESET;
            div_reg <= DIV_RESET;
            por_pending <= 1'b1;
            conv_valid <= 1'b0;
            conv_result <= '0;
            rdata_valid <= 1'b0;
            rdata <= '0;
            reinit_pulse <= 1'b0;
            start_pulse <= 1'b0;
            ext_valid <= 1'b0;
            ext_word <= '0;
        end else begin
            mode_reg <= next_mode_reg;
            div_reg <= next_div_reg;
            por_pending <= next_por_pending;
            conv_valid <= next_conv_valid;
            conv_result <= next_conv_result;
            rdata_valid <= next_rdata_valid;
            rdata <= next_rdata;
            reinit_pulse <= next_reinit_pulse;
            start_pulse <= next_start_pulse;
            ext_valid <= next_ext_valid;
            ext_word <= next_ext_word;
        end
    end

    assign link.rdata_valid = rdata_valid;
    assign link.rdata = rdata;

    // fraction_zero is live, so integer mode follows it without a write
    assign integer_mode = mode_reg[INTEGER_MODE_BIT]
        | (fraction_zero & mode_reg[ZERO_FRAC_SEL_BIT]);
    assign pump_force_source = (mode_reg[PUMP_TEST_HI:PUMP_TEST_LO] == PUMP_TEST_SOURCE);
    assign pump_force_sink = (mode_reg[PUMP_TEST_HI:PUMP_TEST_LO] == PUMP_TEST_SINK);
    assign pump_linearity_mode = (mode_reg[LINEARITY_HI:LINEARITY_LO] != LINEARITY_OFF);
    assign pump_output_clamp = mode_reg[OUTPUT_CLAMP_BIT];
    assign pump_hiz = mode_reg[PUMP_HIZ_BIT];
    assign phase_polarity_positive = mode_reg[POLARITY_BIT];
    assign lock_detect_algorithm = mode_reg[LD_ALGO_BIT];
    assign lock_detect_speed = mode_reg[LD_SPEED_BIT];
    assign lock_detect_window = mode_reg[LD_WINDOW_BIT];
    assign software_power_down = mode_reg[POWER_DOWN_BIT];
    assign counters_hold = mode_reg[COUNTER_HOLD_BIT];
    assign modulator_reinit = reinit_pulse;

    assign reference_stage_off = div_reg[REF_OFF_BIT];
    assign divider_function_select = div_reg[DIV_FN_HI:DIV_FN_LO];
    assign divider_value = div_reg[DIV_VAL_HI:DIV_VAL_LO];
    assign converter_source_select = div_reg[CONV_SRC_HI:CONV_SRC_LO];
    assign conversion_start = start_pulse;

    assign ext_write_valid = ext_valid;
    assign ext_write_word = ext_word;
endmodule
`default_nettype wire

// ===== sim/pll_ctrl_link_monitor.sv
/* Concurrent checks on the host to device word link.
   Assumes both ends share ref_clk and a synchronous active-low rstn. */
`timescale 1ns/1ns
`default_nettype none
module pll_ctrl_link_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // link signals
    input wire logic word_valid,
    input wire logic [pll_ctrl_pkg::WORD_W-1:0] word,
    input wire logic rdata_valid,
    input wire logic [pll_ctrl_pkg::WORD_W-1:0] rdata
);
    import pll_ctrl_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // the divider resets to zero, so only a nonzero write arms its check
    logic div_set;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            div_set <= 1'b0;
        end else if (word_valid && !word[RD_BIT] && word[2:0] == ADDR_DIV
                && word[DIV_VAL_HI:DIV_VAL_LO] != 12'h000) begin
            div_set <= 1'b1;
        end
    end

    AST_RD_ANSWER: assert property (word_valid && word[RD_BIT] |=> rdata_valid)
        else $error("read word not answered next cycle");
    AST_WR_SILENT: assert property (word_valid && !word[RD_BIT] |=> !rdata_valid)
        else $error("write word produced readback");
    AST_RD_FORMAT: assert property (rdata_valid |->
        rdata[RD_BIT] && rdata[2:0] == $past(word[2:0]))
        else $error("readback flag or address wrong");
    AST_RD_PULSE: assert property (rdata_valid |=> !rdata_valid)
        else $error("readback valid longer than one cycle");
    AST_RD_HOLD: assert property (!rdata_valid |-> $stable(rdata))
        else $error("readback word changed without a read");
    AST_MODE_ZERO: assert property (rdata_valid && rdata[2:0] == ADDR_MODE |->
        (rdata & ~(MODE_USED_MASK | ADDR_MASK)) == 32'h80000000)
        else $error("mode readback has unused bits set");
    AST_DIV_ZERO: assert property (rdata_valid && rdata[2:0] == ADDR_DIV |->
        (rdata & ~(DIV_USED_MASK | ADDR_MASK)) == 32'h80000000)
        else $error("divider readback has unused bits set");
    AST_DIV_NONZERO: assert property (rdata_valid && rdata[2:0] == ADDR_DIV && div_set |->
        rdata[DIV_VAL_HI:DIV_VAL_LO] != 12'h000)
        else $error("divider value reads zero after a nonzero write");
    AST_HOST_DIV: assert property (word_valid && !word[RD_BIT] && word[2:0] == ADDR_DIV |->
        word[DIV_VAL_HI:DIV_VAL_LO] != 12'h000)
        else $error("host sent divider word with zero divider");
    AST_STATUS_ZERO: assert property (rdata_valid && rdata[2:0] == ADDR_STATUS |->
        rdata[30:12] == 19'h00000)
        else $error("status readback has unused bits set");
    AST_HOST_MASK: assert property (word_valid && !word[RD_BIT] && word[2:0] == ADDR_MODE |->
        (word & ~(MODE_USED_MASK | ADDR_MASK)) == 32'h00000000)
        else $error("host sent mode word with unused bits");
endmodule
`default_nettype wire

// ===== sim/pll_synth_control_status_regs_bench.sv
/* Bench joining host and device ends through the link interface.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module pll_synth_control_status_regs_bench;
    import pll_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 3'h0;
    logic [WORD_W-1:0] cmd_data = 32'h0;
    logic [17:0] comparator_freq_khz = 18'h09c40;
    logic fraction_zero = 1'b0;
    logic conversion_done = 1'b0;
    logic [6:0] conversion_result = 7'h00;
    logic cmd_ready, rsp_valid, cmd_refused, ext_write_valid;
    logic [WORD_W-1:0] rsp_data, ext_write_word;
    logic integer_mode, pump_force_source, pump_force_sink, pump_linearity_mode;
    logic pump_output_clamp, pump_hiz, phase_polarity_positive, lock_detect_algorithm;
    logic lock_detect_speed, lock_detect_window, software_power_down, counters_hold;
    logic modulator_reinit, reference_stage_off, conversion_start;
    logic [1:0] divider_function_select;
    logic [DIV_VAL_W-1:0] divider_value;
    logic [2:0] converter_source_select;
    int fails = 0;
    int checked = 0;
    int reinit_n = 0;
    int start_n = 0;
    int ext_n = 0;
    int refused_n = 0;
    int n0;

    pll_ctrl_link_if i_pll_ctrl_link_if ();
    pll_ctrl_host i_pll_ctrl_host (.ref_clk, .rstn, .link(i_pll_ctrl_link_if), .cmd_valid,
        .cmd_ready, .cmd_read, .cmd_addr, .cmd_data, .comparator_freq_khz, .rsp_valid,
        .rsp_data, .cmd_refused);
    pll_ctrl_device #(.RES_W(7)) i_pll_ctrl_device (.ref_clk, .rstn,
        .link(i_pll_ctrl_link_if), .fraction_zero, .conversion_done, .conversion_result,
        .integer_mode, .pump_force_source, .pump_force_sink, .pump_linearity_mode,
        .pump_output_clamp, .pump_hiz, .phase_polarity_positive, .lock_detect_algorithm,
        .lock_detect_speed, .lock_detect_window, .software_power_down, .counters_hold,
        .modulator_reinit, .reference_stage_off, .divider_function_select, .divider_value,
        .converter_source_select, .conversion_start, .ext_write_valid, .ext_write_word);
    pll_ctrl_link_monitor i_pll_ctrl_link_monitor (.ref_clk, .rstn,
        .word_valid(i_pll_ctrl_link_if.word_valid), .word(i_pll_ctrl_link_if.word),
        .rdata_valid(i_pll_ctrl_link_if.rdata_valid), .rdata(i_pll_ctrl_link_if.rdata));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // pulses are counted, so checks need not hit their exact cycle
    always @(posedge ref_clk) begin
        if (rstn) begin
            if (modulator_reinit === 1'b1) reinit_n++;
            if (conversion_start === 1'b1) start_n++;
            if (ext_write_valid === 1'b1) ext_n++;
            if (cmd_refused === 1'b1) refused_n++;
        end
    end

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    // host always idle here: reads are waited out before the next call
    task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        int n;
        chk("cmd_ready idle", {31'h0, cmd_ready}, 32'h1);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        if (rd) begin
            for (n = 0; n < 10 && rsp_valid !== 1'b1; n++) begin
                @(posedge ref_clk);
                #1;
                if (n == 0) chk("cmd_ready busy", {31'h0, cmd_ready}, 32'h0);
            end
            if (n == 10) chk("rsp_valid", 32'h0, 32'h1);
        end else begin
            repeat (3) @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        cmd(1'b1, a, 32'h0);
        chk(nm, rsp_data, exp);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk("status por", ADDR_STATUS, 32'h80000806);
        rd_chk("status read", ADDR_STATUS, 32'h80000006);
        rd_chk("mode reset", ADDR_MODE, 32'h80000043);
        rd_chk("div reset", ADDR_DIV, 32'h80000004);
        cmd(1'b0, ADDR_MODE, 32'hffffffff);
        rd_chk("mode ones", ADDR_MODE, 32'h8003fffb);
        chk("mode outs", {22'h0, integer_mode, pump_force_source, pump_force_sink,
            pump_linearity_mode, pump_hiz, lock_detect_algorithm, lock_detect_speed,
            lock_detect_window, software_power_down, counters_hold}, 32'h2ff);
        chk("clamp polarity", {30'h0, pump_output_clamp, phase_polarity_positive}, 32'h3);
        // boundary: exactly 32 MHz keeps the slow setting
        @(posedge ref_clk);
        comparator_freq_khz <= 18'h07d00;
        cmd(1'b0, ADDR_MODE, 32'h0);
        rd_chk("mode zero", ADDR_MODE, 32'h80000003);
        chk("zero outs", {22'h0, integer_mode, pump_force_source, pump_force_sink,
            pump_linearity_mode, pump_hiz, lock_detect_algorithm, lock_detect_speed,
            lock_detect_window, software_power_down, counters_hold}, 32'h0);
        chk("clamp polarity off", {30'h0, pump_output_clamp, phase_polarity_positive}, 32'h0);
        @(posedge ref_clk);
        fraction_zero <= 1'b1;
        cmd(1'b0, ADDR_MODE, 32'h00020000);
        chk("auto integer", {31'h0, integer_mode}, 32'h1);
        cmd(1'b0, ADDR_MODE, 32'h0);
        chk("stay fractional", {31'h0, integer_mode}, 32'h0);
        n0 = reinit_n;
        cmd(1'b0, ADDR_REG0, 32'h00000010);
        chk("reinit on", 32'(reinit_n - n0), 32'h1);
        chk("ext word", ext_write_word, 32'h00000010);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, ADDR_MODE, 32'h4000 | (i << 15) | (i << 11));
            chk("pump test", {30'h0, pump_force_source, pump_force_sink},
                32'(i == 2 ? 2 : i == 3 ? 1 : 0));
            chk("linearity", {31'h0, pump_linearity_mode}, 32'(i != 0));
        end
        cmd(1'b0, ADDR_REG0, 32'h00000010);
        chk("reinit off", 32'(reinit_n - n0), 32'h1);
        chk("ext count", 32'(ext_n), 32'h2);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, ADDR_DIV, 32'h00200000 | (i << 19) | (32'hfff << 7));
            chk("div outs", {17'h0, reference_stage_off, divider_function_select,
                divider_value}, 32'h4fff | (i << 12));
        end
        n0 = start_n;
        cmd(1'b0, ADDR_DIV, 32'h00000088);
        chk("div one", {20'h0, divider_value}, 32'h1);
        chk("start no source", 32'(start_n - n0), 32'h0);
        cmd(1'b0, ADDR_DIV, 32'h00000010);
        chk("zero refused", 32'(refused_n), 32'h1);
        chk("div kept", {20'h0, divider_value}, 32'h1);
        // stored start bit reads back as written
        rd_chk("div readback", ADDR_DIV, 32'h8000008c);
        cmd(1'b0, ADDR_DIV, 32'h00000098);
        chk("start", 32'(start_n - n0), 32'h1);
        chk("temp source", {29'h0, converter_source_select}, 32'h1);
        rd_chk("converting", ADDR_STATUS, 32'h80000006);
        @(posedge ref_clk);
        conversion_result <= 7'h55;
        conversion_done <= 1'b1;
        @(posedge ref_clk);
        conversion_done <= 1'b0;
        rd_chk("result", ADDR_STATUS, 32'h800006ae);
        rd_chk("unmapped", 3'h5, 32'h80000005);
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
